// *** laser_ctl_password_shutdown_regs_bench.sv ***
// laser_ctl_password_shutdown_regs_bench: self-checking bench of the register bank
// assumes lps_host as the access partner and the bound port checker
`timescale 1ns/1ps
module laser_ctl_password_shutdown_regs_bench;
   localparam logic [2:0] OK = 3'b010;
   localparam logic [2:0] NO = 3'b001;
   logic        clk = 1'b0, rst_n = 1'b0, bias_high_trip = 1'b0;
   logic        first_level_ok = 1'b0, second_level_ok = 1'b0;
   logic [15:0] tx_power_meas = 16'hFFFF, rx_power_meas = 16'hFFFF;
   logic        acc_wr, acc_rd, acc_aux, acc_rvalid, acc_wr_done, acc_wr_refused;
   logic        mask_set_sel, tx_power_high_trip, tx_power_low_trip, rx_signal_loss;
   logic        laser_cutoff_gate_out;
   logic [7:0]  acc_addr, acc_wdata, acc_rdata, table_select;
   wire  [7:0]  outs = {3'b0, mask_set_sel, tx_power_high_trip, tx_power_low_trip,
                        rx_signal_loss, laser_cutoff_gate_out};
   int          error_cnt = 0, cmp_count = 0;
   // {table, address, value} and {aux, table, address}
   logic [23:0] fac [11] = '{24'h04C300, 24'h04C600, 24'h04C701, 24'h04DA00, 24'h04DBFF,
                             24'h04DC00, 24'h04DD00, 24'h05D100, 24'h05C05A, 24'h05C13C,
                             24'h05C201};
   logic [16:0] rgn [8]  = '{17'h10500, 17'h10580, 17'h00510, 17'h00180, 17'h001F8,
                             17'h004C7, 17'h005F8, 17'h005D3};
   always #2 clk = ~clk;
   lps_regs #(.MEAS_W(16)) u_dut (.clk, .rst_n, .acc_wr, .acc_rd, .acc_aux, .acc_addr,
      .acc_wdata, .first_level_ok, .second_level_ok, .tx_power_meas, .rx_power_meas,
      .bias_high_trip, .acc_rdata, .acc_rvalid, .acc_wr_done, .acc_wr_refused, .table_select,
      .mask_set_sel, .tx_power_high_trip, .tx_power_low_trip, .rx_signal_loss,
      .laser_cutoff_gate_out);
   lps_host u_host (.clk, .acc_rdata, .acc_rvalid, .acc_wr_done, .acc_wr_refused, .acc_wr,
      .acc_rd, .acc_aux, .acc_addr, .acc_wdata);
   // ------------------------------------------------------------
   // compare, access and stimulus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic aux, input logic [7:0] addr, data, input logic [2:0] exp);
      logic [7:0] d;
      logic [2:0] st;
      u_host.xfer(1'b1, aux, addr, data, d, st);
      chk({5'b0, st}, {5'b0, exp});
   endtask
   task automatic rd(input logic [7:0] addr, exp);
      logic [7:0] d;
      logic [2:0] st;
      u_host.xfer(1'b0, 1'b0, addr, 8'h00, d, st);
      chk({5'b0, st}, 8'h04);
      chk(d, exp);
   endtask
   // drive measurements, let trips settle, compare status outputs
   task automatic meas(input logic [15:0] tx, rx, input logic bias, input logic [7:0] exp);
      @(posedge clk);
      tx_power_meas  <= tx;
      rx_power_meas  <= rx;
      bias_high_trip <= bias;
      repeat (5) @(posedge clk);
      #1;
      chk(outs, exp);
   endtask
   task automatic setok(input logic f, s);
      @(posedge clk);
      first_level_ok  <= f;
      second_level_ok <= s;
   endtask
   task automatic finish_test;
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #20000;
      error_cnt++;
      finish_test();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(table_select, 8'h01);
      chk(outs, 8'h01);
      for (int i = 0; i < 11; i++) begin
         wr(1'b0, 8'h7F, fac[i][23:16], OK);
         rd(fac[i][15:8], fac[i][7:0]);
      end
      wr(1'b0, 8'hC0, 8'h00, OK);
      rd(8'hC0, 8'h5A);
      wr(1'b0, 8'h7F, 8'h04, OK);
      wr(1'b0, 8'hDA, 8'hFF, OK);
      rd(8'hDA, 8'hF1);
      meas(16'h80FF, 16'h8000, 1'b0, 8'h10);
      wr(1'b0, 8'hDB, 8'h80, OK);
      meas(16'h80FF, 16'h8000, 1'b0, 8'h10);
      meas(16'h8100, 16'h8000, 1'b0, 8'h19);
      wr(1'b0, 8'hDA, 8'hB1, OK);
      meas(16'h8100, 16'h8000, 1'b0, 8'h18);
      wr(1'b0, 8'hDC, 8'h40, OK);
      meas(16'h3FFF, 16'h8000, 1'b0, 8'h15);
      wr(1'b0, 8'hDA, 8'hA1, OK);
      meas(16'h3FFF, 16'h8000, 1'b0, 8'h14);
      meas(16'h8000, 16'h8000, 1'b1, 8'h11);
      wr(1'b0, 8'hDA, 8'h21, OK);
      meas(16'h8000, 16'h8000, 1'b1, 8'h10);
      wr(1'b0, 8'hDA, 8'h00, OK);
      meas(16'h8000, 16'h8000, 1'b1, 8'h01);
      wr(1'b0, 8'hDD, 8'h20, OK);
      meas(16'h8000, 16'h1FFF, 1'b0, 8'h03);
      meas(16'h8000, 16'h2000, 1'b0, 8'h01);
      // each guard bit: locked write dropped, then opened by first level (odd bits) or second level (even bits)
      for (int b = 0; b < 8; b++) begin
         wr(1'b0, 8'h7F, 8'h05, OK);
         wr(1'b0, 8'hD1, 8'h01 << b, OK);
         wr(1'b0, 8'h7F, rgn[b][15:8], OK);
         wr(rgn[b][16], rgn[b][7:0], 8'h09, NO);
         if (b == 5)
            rd(8'hC7, 8'h01);
         setok(b[0], !b[0]);
         wr(rgn[b][16], rgn[b][7:0], 8'h09, OK);
         wr(1'b0, 8'h7F, 8'h05, OK);
         wr(1'b0, 8'hD1, 8'h00, OK);
         setok(1'b0, 1'b0);
      end
      finish_test();
   end
endmodule

// *** lps_host.sv ***
// lps_host: two-wire host side model issuing single byte accesses
// assumes the bank registers its answer on the taking edge itself
`timescale 1ns/1ps
module lps_host (
   input  wire logic       clk,            // bank clock
   input  wire logic [7:0] acc_rdata,      // read byte
   input  wire logic       acc_rvalid,     // read answer pulse
   input  wire logic       acc_wr_done,    // write accepted pulse
   input  wire logic       acc_wr_refused, // write dropped pulse
   output logic            acc_wr,         // write strobe
   output logic            acc_rd,         // read strobe
   output logic            acc_aux,        // auxiliary space select
   output logic [7:0]      acc_addr,       // byte address
   output logic [7:0]      acc_wdata       // write byte
);
   // idle bus at time zero
   initial begin
      acc_wr    = 1'b0;
      acc_rd    = 1'b0;
      acc_aux   = 1'b0;
      acc_addr  = 8'h00;
      acc_wdata = 8'h00;
   end
   // strobe over one taking edge, answer read after it
   task automatic xfer(input logic wr, input logic aux, input logic [7:0] addr,
                       input logic [7:0] data, output logic [7:0] rdata,
                       output logic [2:0] st);
      @(posedge clk);
      acc_wr    <= wr;
      acc_rd    <= !wr;
      acc_aux   <= aux;
      acc_addr  <= addr;
      acc_wdata <= data;
      @(posedge clk);
      acc_wr    <= 1'b0;
      acc_rd    <= 1'b0;
      acc_addr  <= ~addr;  // no stale value
      acc_wdata <= ~data;
      #1;
      rdata = acc_rdata;
      st    = {acc_rvalid, acc_wr_done, acc_wr_refused};
   endtask
endmodule

// *** lps_pkg.sv ***
// lps_pkg: constants of the laser controller password and shutdown register bank
// assumes byte-wide access from a two-wire slave front end on the same clock
package lps_pkg;

   // ------------------------------------------------------------------
   // memory tables and upper-memory boundary
   // ------------------------------------------------------------------
   localparam logic [7:0] TBL_LIMITS    = 8'h01;   // user table holding mask set B
   localparam logic [7:0] TBL_CAL_A     = 8'h02;
   localparam logic [7:0] TBL_CAL_B     = 8'h03;
   localparam logic [7:0] TBL_CONFIG    = 8'h04;   // second password, shutdown config
   localparam logic [7:0] TBL_SECURITY  = 8'h05;   // identity, first password
   localparam logic [7:0] UPPER_BASE    = 8'h80;   // first upper-memory byte

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_TABLE_SELECT      = 8'h7F;   // lower memory, volatile
   localparam logic [7:0] OFS_DEVICE_IDENTITY_HI      = 8'hC0;
   localparam logic [7:0] OFS_DEVICE_IDENTITY_LO      = 8'hC1;
   localparam logic [7:0] OFS_DESIGN_REVISION   = 8'hC2;
   localparam logic [7:0] OFS_SECOND_PW_FIRST   = 8'hC3;   // most significant byte
   localparam logic [7:0] OFS_SECOND_PW_LAST    = 8'hC6;
   localparam logic [7:0] OFS_TABLE_SELECT_BOOT = 8'hC7;
   localparam logic [7:0] OFS_FIRST_WP_ENABLES  = 8'hD1;
   localparam logic [7:0] OFS_FIRST_PW_FIRST    = 8'hD3;   // most significant byte
   localparam logic [7:0] OFS_FIRST_PW_LAST     = 8'hD6;
   localparam logic [7:0] OFS_SHUTDOWN_CONFIG   = 8'hDA;
   localparam logic [7:0] OFS_TX_POWER_UPPER    = 8'hDB;
   localparam logic [7:0] OFS_TX_POWER_LOWER    = 8'hDC;
   localparam logic [7:0] OFS_RX_LOSS_LIMIT     = 8'hDD;

   // ------------------------------------------------------------------
   // protected region bounds
   // ------------------------------------------------------------------
   localparam logic [7:0] RGN_SEC_LO     = 8'hD0;
   localparam logic [7:0] RGN_SEC_HI     = 8'hD6;
   localparam logic [7:0] RGN_MASK_LO    = 8'hF8;   // mask bytes F8h..FFh
   localparam logic [7:0] RGN_CFG_HI     = 8'hC7;
   localparam logic [7:0] RGN_USER_HI    = 8'hF7;
   localparam logic [7:0] RGN_LOWER_HI   = 8'h7A;

   // ------------------------------------------------------------------
   // shutdown configuration fields
   // ------------------------------------------------------------------
   localparam int SD_POLARITY_BIT  = 7;
   localparam int SD_TXH_EN_BIT    = 6;
   localparam int SD_BIAS_EN_BIT   = 5;
   localparam int SD_TXL_EN_BIT    = 4;
   localparam int SD_MASK_SEL_BIT  = 0;
   localparam logic [7:0] SD_WRITABLE = 8'hF1;      // bits 3..1 unused, read zero

   // ------------------------------------------------------------------
   // write-protection enable bit positions
   // ------------------------------------------------------------------
   localparam int WP_SEC_BIT       = 7;
   localparam int WP_SEC_MASK_BIT  = 6;
   localparam int WP_CFG_BIT       = 5;
   localparam int WP_USER_MASK_BIT = 4;
   localparam int WP_USER_BIT      = 3;
   localparam int WP_LOWER_BIT     = 2;
   localparam int WP_AUX_HI_BIT    = 1;
   localparam int WP_AUX_LO_BIT    = 0;

   // ------------------------------------------------------------------
   // factory values
   // ------------------------------------------------------------------
   localparam logic [31:0] RST_PASSWORD      = 32'h0000_0000;
   localparam logic [7:0]  RST_TABLE_BOOT    = 8'h01;
   localparam logic [7:0]  RST_WP_ENABLES    = 8'h00;
   localparam logic [7:0]  RST_SHUTDOWN      = 8'h00;
   localparam logic [7:0]  RST_TX_UPPER      = 8'hFF;
   localparam logic [7:0]  RST_TX_LOWER      = 8'h00;
   localparam logic [7:0]  RST_RX_LOSS       = 8'h00;
   localparam logic [15:0] DEFAULT_DEVICE_IDENTITY = 16'h5A3C;  // arbitrary value
   localparam logic [7:0]  DEFAULT_REVISION  = 8'h01;     // arbitrary value

endpackage

// *** lps_regs.sv ***
// lps_regs: password, table-select and shutdown register bank with trip logic
// assumes a two-wire slave front end on clk that hands over one byte access
// at a time as single-cycle strobes; password matching is done elsewhere
`timescale 1ns/1ps

// How it works
// - 32-bit second password in C3h..C6h, MSB first, factory zero.
// - boot value (factory 01h) copied into table select 7Fh after power up.
// - config bit 7 sets the cutoff output level during shutdown.
// - config bit 6 lets a transmit-power-high trip cause shutdown.
// - config bit 5 lets a bias-current-high trip cause shutdown.
// - config bit 4 lets a transmit-power-low trip cause shutdown; bits 3..1 unused.
// - config bit 0 selects interrupt mask set: table 05h or 01h.
// - high power limit, factory FFh, compared with top 8 measurement bits.
// - low power limit, factory 00h, compared with top 8 measurement bits.
// - signal loss limit, factory 00h, low limit on top 8 RSSI bits.
// - C0h and C1h return a fixed read-only 16-bit identity.
// - C2h returns the fixed read-only design revision.
// - write-protect bit 7 guards table 05h bytes D0h..D6h.
// - write-protect bit 6 guards table 05h bytes F8h..FFh.
// - write-protect bit 5 guards bytes 80h..C7h of tables 04h, 02h, 03h.
// - write-protect bit 4 guards table 01h bytes F8h..FFh.
// - write-protect bit 3 guards table 01h bytes 80h..F7h.
// - write-protect bit 2 guards lower memory bytes 00h..7Ah.
// - write-protect bit 1 guards auxiliary memory bytes 80h..FFh.
// - write-protect bit 0 guards auxiliary memory bytes 00h..7Fh.
// - 32-bit first password in table 05h D3h..D6h, MSB first.
module lps_regs #(
   parameter int          MEAS_W    = 16,                         // measurement width
   parameter logic [15:0] DEVICE_IDENTITY = lps_pkg::DEFAULT_DEVICE_IDENTITY, // arbitrary value
   parameter logic [7:0]  REVISION  = lps_pkg::DEFAULT_REVISION   // arbitrary value
) (
   input  wire logic              clk,              // 250 MHz core clock
   input  wire logic              rst_n,            // synchronous power-up reset
   input  wire logic              acc_wr,           // write strobe, one cycle
   input  wire logic              acc_rd,           // read strobe, one cycle
   input  wire logic              acc_aux,          // 1 = auxiliary two-wire memory
   input  wire logic [7:0]        acc_addr,         // byte address
   input  wire logic [7:0]        acc_wdata,        // write byte
   input  wire logic              first_level_ok,   // first password matched
   input  wire logic              second_level_ok,  // second password matched
   input  wire logic [MEAS_W-1:0] tx_power_meas,    // transmit power measurement
   input  wire logic [MEAS_W-1:0] rx_power_meas,    // received strength measurement
   input  wire logic              bias_high_trip,   // bias comparator, asynchronous
   output logic [7:0]             acc_rdata,        // read byte
   output logic                   acc_rvalid,       // read data valid pulse
   output logic                   acc_wr_done,      // write accepted pulse
   output logic                   acc_wr_refused,   // write dropped pulse
   output logic [7:0]             table_select,     // volatile table selector
   output logic                   mask_set_sel,     // 0 = table 05h masks
   output logic                   tx_power_high_trip, // high power trip level
   output logic                   tx_power_low_trip,  // low power trip level
   output logic                   rx_signal_loss,     // signal loss level
   output logic                   laser_cutoff_gate_out // laser cutoff drive
);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   if (MEAS_W < 8) begin : g_meas_check
      $error("lps_regs: MEAS_W must be at least 8");
   end

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] second_pw;
      logic [31:0] first_pw;
      logic [7:0]  boot_tsel;
      logic [7:0]  tsel;
      logic        boot_pending;
      logic [7:0]  wp_en;
      logic [7:0]  sd_cfg;
      logic [7:0]  tx_upper;
      logic [7:0]  tx_lower;
      logic [7:0]  rx_loss;
      logic        bias_s1;
      logic        bias_s2;
      logic        txh;
      logic        txl;
      logic        rx_signal_loss_limit;
      logic        cutoff;
      logic [7:0]  rdata;
      logic        rvalid;
      logic        wr_done;
      logic        wr_refused;
   } lps_state_t;

   lps_state_t cur;
   lps_state_t nxt;

   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------
   // which write-protect enables cover a byte
   function automatic logic [7:0] lps_region(input logic aux, input logic [7:0] tbl,
                                             input logic [7:0] a);
      logic [7:0] m;
      logic       up;
      logic       mn;
      m  = 8'h00;
      up = (a >= lps_pkg::UPPER_BASE);
      mn = !aux && up;
      m[lps_pkg::WP_SEC_BIT] = mn && tbl == lps_pkg::TBL_SECURITY &&
                     a >= lps_pkg::RGN_SEC_LO && a <= lps_pkg::RGN_SEC_HI;
      m[lps_pkg::WP_SEC_MASK_BIT] = mn && tbl == lps_pkg::TBL_SECURITY &&
                     a >= lps_pkg::RGN_MASK_LO;
      m[lps_pkg::WP_CFG_BIT] = mn && a <= lps_pkg::RGN_CFG_HI &&
                     (tbl == lps_pkg::TBL_CONFIG || tbl == lps_pkg::TBL_CAL_A ||
                      tbl == lps_pkg::TBL_CAL_B);
      m[lps_pkg::WP_USER_MASK_BIT] = mn && tbl == lps_pkg::TBL_LIMITS &&
                     a >= lps_pkg::RGN_MASK_LO;
      m[lps_pkg::WP_USER_BIT] = mn && tbl == lps_pkg::TBL_LIMITS &&
                     a <= lps_pkg::RGN_USER_HI;
      m[lps_pkg::WP_LOWER_BIT]  = !aux && a <= lps_pkg::RGN_LOWER_HI;
      m[lps_pkg::WP_AUX_HI_BIT] = aux && up;
      m[lps_pkg::WP_AUX_LO_BIT] = aux && !up;
      return m;
   endfunction

   // byte lane of a four-byte password, most significant at the lowest address
   function automatic logic [31:0] lps_put_byte(input logic [31:0] w,
                                                input logic [7:0] a,
                                                input logic [7:0] d);
      logic [31:0] r;
      logic [1:0]  idx;
      r   = w;
      idx = 2'(a[1:0] + 2'h1);         // 0 = most significant byte
      case (idx)
         2'h0: r[31:24] = d;
         2'h1: r[23:16] = d;
         2'h2: r[15:8]  = d;
         default: r[7:0] = d;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   logic       upper;
   logic       in_cfg;
   logic       in_sec;
   logic [7:0] covered;
   logic       allowed;
   logic       shutdown;

   // upper memory reaches the table picked by the selector byte
   always_comb begin
      upper   = !acc_aux && acc_addr >= lps_pkg::UPPER_BASE;
      in_cfg  = upper && cur.tsel == lps_pkg::TBL_CONFIG;
      in_sec  = upper && cur.tsel == lps_pkg::TBL_SECURITY;
      covered = lps_region(acc_aux, cur.tsel, acc_addr);
      // either password level opens first-level regions
      allowed = ((covered & cur.wp_en) == 8'h00) || first_level_ok ||
                second_level_ok;
   end

   // shutdown from enabled trip sources
   always_comb begin
      shutdown = (cur.sd_cfg[lps_pkg::SD_TXH_EN_BIT]  && cur.txh) ||
                 (cur.sd_cfg[lps_pkg::SD_BIAS_EN_BIT] && cur.bias_s2) ||
                 (cur.sd_cfg[lps_pkg::SD_TXL_EN_BIT]  && cur.txl);
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt            = cur;
      nxt.rvalid     = 1'b0;
      nxt.wr_done    = 1'b0;
      nxt.wr_refused = 1'b0;

      // bias comparator passes two flops
      nxt.bias_s1 = bias_high_trip;
      nxt.bias_s2 = cur.bias_s1;

      // threshold compares on the top byte of each measurement
      nxt.txh = tx_power_meas[MEAS_W-1 -: 8] > cur.tx_upper;
      nxt.txl = tx_power_meas[MEAS_W-1 -: 8] < cur.tx_lower;
      nxt.rx_signal_loss_limit = rx_power_meas[MEAS_W-1 -: 8] < cur.rx_loss;

      // cutoff level follows the polarity bit while shut down
      nxt.cutoff = shutdown ? cur.sd_cfg[lps_pkg::SD_POLARITY_BIT] :
                              !cur.sd_cfg[lps_pkg::SD_POLARITY_BIT];

      // one-time load of the selector from its stored boot value
      if (cur.boot_pending) begin
         nxt.tsel         = cur.boot_tsel;
         nxt.boot_pending = 1'b0;
      end

      // read path
      if (acc_rd) begin
         nxt.rvalid = 1'b1;
         nxt.rdata  = 8'h00;
         if (!acc_aux && acc_addr == lps_pkg::OFS_TABLE_SELECT) begin
            nxt.rdata = cur.tsel;
         end else if (in_sec) begin
            case (acc_addr)
               lps_pkg::OFS_DEVICE_IDENTITY_HI:     nxt.rdata = DEVICE_IDENTITY[15:8];
               lps_pkg::OFS_DEVICE_IDENTITY_LO:     nxt.rdata = DEVICE_IDENTITY[7:0];
               lps_pkg::OFS_DESIGN_REVISION:  nxt.rdata = REVISION;
               lps_pkg::OFS_FIRST_WP_ENABLES: nxt.rdata = cur.wp_en;
               default:                       nxt.rdata = 8'h00;  // passwords hidden
            endcase
         end else if (in_cfg) begin
            case (acc_addr)
               lps_pkg::OFS_TABLE_SELECT_BOOT: nxt.rdata = cur.boot_tsel;
               lps_pkg::OFS_SHUTDOWN_CONFIG:   nxt.rdata = cur.sd_cfg;
               lps_pkg::OFS_TX_POWER_UPPER:    nxt.rdata = cur.tx_upper;
               lps_pkg::OFS_TX_POWER_LOWER:    nxt.rdata = cur.tx_lower;
               lps_pkg::OFS_RX_LOSS_LIMIT:     nxt.rdata = cur.rx_loss;
               default:                        nxt.rdata = 8'h00;  // passwords hidden
            endcase
         end
      end

      // write path; a refused write leaves every byte as it was
      if (acc_wr) begin
         if (!allowed) begin
            nxt.wr_refused = 1'b1;
         end else begin
            nxt.wr_done = 1'b1;
            if (!acc_aux && acc_addr == lps_pkg::OFS_TABLE_SELECT) begin
               nxt.tsel = acc_wdata;
            end else if (in_cfg) begin
               if (acc_addr >= lps_pkg::OFS_SECOND_PW_FIRST &&
                   acc_addr <= lps_pkg::OFS_SECOND_PW_LAST) begin
                  nxt.second_pw = lps_put_byte(cur.second_pw, acc_addr, acc_wdata);
               end
               case (acc_addr)
                  lps_pkg::OFS_TABLE_SELECT_BOOT: nxt.boot_tsel = acc_wdata;
                  lps_pkg::OFS_SHUTDOWN_CONFIG:
                     nxt.sd_cfg = acc_wdata & lps_pkg::SD_WRITABLE;
                  lps_pkg::OFS_TX_POWER_UPPER:    nxt.tx_upper = acc_wdata;
                  lps_pkg::OFS_TX_POWER_LOWER:    nxt.tx_lower = acc_wdata;
                  lps_pkg::OFS_RX_LOSS_LIMIT:     nxt.rx_loss  = acc_wdata;
                  default: ;
               endcase
            end else if (in_sec) begin
               if (acc_addr == lps_pkg::OFS_FIRST_WP_ENABLES) begin
                  nxt.wp_en = acc_wdata;
               end
               if (acc_addr >= lps_pkg::OFS_FIRST_PW_FIRST &&
                   acc_addr <= lps_pkg::OFS_FIRST_PW_LAST) begin
                  nxt.first_pw = lps_put_byte(cur.first_pw, acc_addr, acc_wdata);
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur.second_pw    <= lps_pkg::RST_PASSWORD;
         cur.first_pw     <= lps_pkg::RST_PASSWORD;
         cur.boot_tsel    <= lps_pkg::RST_TABLE_BOOT;
         cur.tsel         <= lps_pkg::RST_TABLE_BOOT;
         cur.boot_pending <= 1'b1;
         cur.wp_en        <= lps_pkg::RST_WP_ENABLES;
         cur.sd_cfg       <= lps_pkg::RST_SHUTDOWN;
         cur.tx_upper     <= lps_pkg::RST_TX_UPPER;
         cur.tx_lower     <= lps_pkg::RST_TX_LOWER;
         cur.rx_loss      <= lps_pkg::RST_RX_LOSS;
         cur.bias_s1      <= 1'b0;
         cur.bias_s2      <= 1'b0;
         cur.txh          <= 1'b0;
         cur.txl          <= 1'b0;
         cur.rx_signal_loss_limit          <= 1'b0;
         cur.cutoff       <= 1'b1;      // idle level for the factory polarity
         cur.rdata        <= 8'h00;
         cur.rvalid       <= 1'b0;
         cur.wr_done      <= 1'b0;
         cur.wr_refused   <= 1'b0;
      end else begin
         cur <= nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs straight from flops
   // ------------------------------------------------------------------
   assign acc_rdata             = cur.rdata;
   assign acc_rvalid            = cur.rvalid;
   assign acc_wr_done           = cur.wr_done;
   assign acc_wr_refused        = cur.wr_refused;
   assign table_select          = cur.tsel;
   assign mask_set_sel          = cur.sd_cfg[lps_pkg::SD_MASK_SEL_BIT];
   assign tx_power_high_trip    = cur.txh;
   assign tx_power_low_trip     = cur.txl;
   assign rx_signal_loss        = cur.rx_signal_loss_limit;
   assign laser_cutoff_gate_out = cur.cutoff;

endmodule

// *** lps_regs_props.sv ***
// lps_regs_props: port assertions for the password and shutdown register bank
// assumes one clock domain and the bank's own port names
`timescale 1ns/1ps
module lps_regs_props #(
   parameter int          MEAS_W    = 16,                         // measurement width
   parameter logic [15:0] DEVICE_IDENTITY = lps_pkg::DEFAULT_DEVICE_IDENTITY, // arbitrary value
   parameter logic [7:0]  REVISION  = lps_pkg::DEFAULT_REVISION   // arbitrary value
) (
   input wire logic              clk,                // clock
   input wire logic              rst_n,              // reset
   input wire logic              acc_wr,             // write strobe
   input wire logic              acc_rd,             // read strobe
   input wire logic              acc_aux,            // aux space
   input wire logic [7:0]        acc_addr,           // byte address
   input wire logic [7:0]        acc_wdata,          // write byte
   input wire logic              first_level_ok,     // level one open
   input wire logic              second_level_ok,    // level two open
   input wire logic [MEAS_W-1:0] tx_power_meas,      // transmit power
   input wire logic [MEAS_W-1:0] rx_power_meas,      // rx strength
   input wire logic [7:0]        acc_rdata,          // read byte
   input wire logic              acc_wr_done,        // write accepted
   input wire logic              acc_wr_refused,     // write dropped
   input wire logic [7:0]        table_select,       // selector
   input wire logic              mask_set_sel,       // mask set
   input wire logic              tx_power_high_trip, // high power trip
   input wire logic              tx_power_low_trip,  // low power trip
   input wire logic              rx_signal_loss      // signal loss
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // bus answers and trips
   // ------------------------------------------------------------
   property p_id_hi;
      acc_rd && !acc_aux && acc_addr == 8'hC0 && table_select == 8'h05
      |=> acc_rdata == DEVICE_IDENTITY[15:8];
   endproperty
   a_id_hi: assert property (p_id_hi) else $error("id high byte wrong");
   property p_rev;
      acc_rd && !acc_aux && acc_addr == 8'hC2 && table_select == 8'h05 |=> acc_rdata == REVISION;
   endproperty
   a_rev: assert property (p_rev) else $error("revision wrong");
   property p_pw_hidden;
      acc_rd && !acc_aux && acc_addr inside {[8'hC3:8'hC6]} && table_select == 8'h04
      |=> acc_rdata == 8'h00;
   endproperty
   a_pw_hidden: assert property (p_pw_hidden) else $error("password shown");
   property p_ack;
      acc_wr |=> acc_wr_done != acc_wr_refused;
   endproperty
   a_ack: assert property (p_ack) else $error("write answer count");
   property p_unlocked;
      acc_wr && (first_level_ok || second_level_ok) |=> acc_wr_done;
   endproperty
   a_unlocked: assert property (p_unlocked) else $error("unlocked write dropped");
   property p_tsel;
      acc_wr && !acc_aux && acc_addr == 8'h7F |=> table_select == $past(acc_wdata);
   endproperty
   a_tsel: assert property (p_tsel) else $error("selector write lost");
   property p_mask;
      acc_wr && !acc_aux && acc_addr == 8'hDA && table_select == 8'h04
      |=> mask_set_sel == $past(acc_wdata[0]);
   endproperty
   a_mask: assert property (p_mask) else $error("mask select wrong");
   property p_txh;
      tx_power_meas[15:8] == 8'hFF |=> !tx_power_high_trip;
   endproperty
   a_txh: assert property (p_txh) else $error("high trip at full scale");
   property p_low;
      tx_power_meas[15:8] == 8'hFF && rx_power_meas[15:8] == 8'hFF
      |=> !tx_power_low_trip && !rx_signal_loss;
   endproperty
   a_low: assert property (p_low) else $error("low trip at full scale");
endmodule

bind lps_regs lps_regs_props #(.MEAS_W(MEAS_W), .DEVICE_IDENTITY(DEVICE_IDENTITY), .REVISION(REVISION))
   u_props (.clk, .rst_n, .acc_wr, .acc_rd, .acc_aux, .acc_addr, .acc_wdata, .first_level_ok,
            .second_level_ok, .tx_power_meas, .rx_power_meas, .acc_rdata, .acc_wr_done,
            .acc_wr_refused, .table_select, .mask_set_sel, .tx_power_high_trip,
            .tx_power_low_trip, .rx_signal_loss);
